// [rtl/adc_config_alert_regs.sv]
// Operation
// - ratio field off: resolution bit ignored, default result width
// - averaging on and resolution bit one: results two bits wider
// - config one bit 1: zero internal reference, one external
// - config one bit 0: zero normal operation, one shutdown
// - top four bits of each config word carry the register address, decoded
// - config two bit 8: zero both outputs, one first output only
// - code 0x3C: soft reset, keep registers, clear checksum alert, flush
// - code 0xFF: hard reset, config and alert registers to defaults
// - any other reset code is ignored
// - alert bit 9 set on checksum-rejected write, cleared by alert read
// - alert bit 8 set on startup load failure, not cleared by read
// - only hard reset clears load failure flag and reruns the load
// - config two at 0x2, resets to zero
// - alert at 0x3, resets to zero, fully read-only
// - alert enable acts only with one-wire output, second pin flags
// - ratio codes 001, 010, 011 enable averaging; others disable
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`default_nettype none
module adc_config_alert_regs
#(
  parameter int unsigned ADDR_W = 6
)
(
  // clock and reset
  input  wire logic                            clock,
  input  wire logic                            resetn,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]               address,
  input  wire logic                            read,
  input  wire logic                            write,
  input  wire logic [adc_cfg_pkg::BUS_W-1:0]   writedata,
  input  wire logic [3:0]                      byteenable,
  output var  logic [adc_cfg_pkg::BUS_W-1:0]   readdata,
  output var  logic                            waitrequest,
  // events from the serial front end and loader
  input  wire logic                            crc_reject_pulse,
  input  wire logic                            load_fail_pulse,
  // converter controls
  output var  adc_cfg_pkg::conv_ctrl_t         conv_ctrl,
  output var  adc_cfg_pkg::reset_cmd_t         reset_cmd,
  output var  logic                            flag_pin,
  // interrupt
  output var  logic                            irq
);
  import adc_cfg_pkg::*;

  // the register map needs index bits [5:2]
  if (ADDR_W < 6)
  begin : g_addr_check
    $error("address width too small for register map");
  end

  logic                 waitrequest_q;
  logic [15:0]          readdata_q;
  logic [15:0]          rd_d;
  logic [3:0]           idx;
  logic                 wr_take;
  logic                 rd_take;
  logic                 lanes_ok;
  logic                 field_ok;
  logic [15:0]          config_one_q;
  logic                 lane_q;
  logic                 c2_seen_q;
  logic [7:0]           cmd;
  logic                 soft_hit;
  logic                 hard_hit;
  logic                 crc_flag;
  logic                 load_flag;
  logic                 crc_clr;
  logic [IRQ_W-1:0]     irq_set;
  logic [IRQ_W-1:0]     irq_clr;
  logic [IRQ_W-1:0]     irq_status;
  logic [IRQ_W-1:0]     irq_mask_q;
  logic                 ratio_on;
  logic [1:0]           shift_d;
  conv_ctrl_t           conv_ctrl_q;
  reset_cmd_t           reset_cmd_q;
  logic                 flag_pin_q;
  logic                 irq_q;

  // bus decode: one wait cycle, then the access is taken
  assign idx      = address[5:2];
  assign wr_take  = write & ~waitrequest_q;
  assign rd_take  = read & ~waitrequest_q;
  assign lanes_ok = (byteenable[1:0] == 2'b11);
  assign field_ok = (writedata[15:ADDR_FIELD_LO] == idx);
  assign cmd      = writedata[C2_CMD_LO +: 8];

  // reset command decode on a valid config two write
  assign soft_hit = wr_take & lanes_ok & field_ok & (idx == IDX_CONFIG_TWO)
                    & (cmd == CMD_SOFT_RESET);
  assign hard_hit = wr_take & lanes_ok & field_ok & (idx == IDX_CONFIG_TWO)
                    & (cmd == CMD_HARD_RESET);

  // waitrequest drops for one cycle after each request
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      waitrequest_q <= 1'b1;
    end
    else
    begin
      waitrequest_q <= ~((read | write) & waitrequest_q);
    end
  end

  // read data mux
  always_comb
  begin
    rd_d = 16'h0000;
    case (idx)
      IDX_CONFIG_ONE:
      begin
        rd_d = config_one_q;
      end
      IDX_CONFIG_TWO:
      begin
        rd_d = CONFIG_TWO_RST;
        // address field reads zero until the first accepted write
        rd_d[15:ADDR_FIELD_LO] = c2_seen_q ? IDX_CONFIG_TWO : CONFIG_TWO_RST[15:12];
        rd_d[C2_LANE_BIT] = lane_q;
      end
      IDX_ALERT:
      begin
        rd_d = ALERT_RST;
        rd_d[AL_CRC_BIT] = crc_flag;
        rd_d[AL_LOAD_BIT] = load_flag;
      end
      IDX_IRQ_STATUS:
      begin
        rd_d[IRQ_W-1:0] = irq_status;
      end
      IDX_IRQ_MASK:
      begin
        rd_d[IRQ_W-1:0] = irq_mask_q;
      end
      default:
      begin
        rd_d = 16'h0000;
      end
    endcase
  end

  // read data captured in the cycle waitrequest falls
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      readdata_q <= 16'h0000;
    end
    else if (read & waitrequest_q)
    begin
      readdata_q <= rd_d;
    end
  end

  // first configuration register
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      config_one_q <= CONFIG_ONE_RST;
    end
    else if (hard_hit)
    begin
      config_one_q <= CONFIG_ONE_RST;
    end
    else if (wr_take & lanes_ok & field_ok & (idx == IDX_CONFIG_ONE))
    begin
      config_one_q <= (writedata[15:0] & C1_WRITE_MASK)
                      | {IDX_CONFIG_ONE, 12'h000};
    end
  end

  // lane bit and address field of config two; command field is not stored
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      lane_q    <= CONFIG_TWO_RST[C2_LANE_BIT];
      c2_seen_q <= 1'b0;
    end
    else if (hard_hit)
    begin
      lane_q    <= CONFIG_TWO_RST[C2_LANE_BIT];
      c2_seen_q <= 1'b0;
    end
    else if (wr_take & lanes_ok & field_ok & (idx == IDX_CONFIG_TWO))
    begin
      lane_q    <= writedata[C2_LANE_BIT];
      c2_seen_q <= 1'b1;
    end
  end

  // averaging active only for the three ratio codes
  always_comb
  begin
    ratio_on = 1'b0;
    shift_d  = 2'b00;
    case (config_one_q[C1_RATIO_LO +: 3])
      RATIO_X2:
      begin
        ratio_on = 1'b1;
        shift_d  = 2'b01;
      end
      RATIO_X4:
      begin
        ratio_on = 1'b1;
        shift_d  = 2'b10;
      end
      RATIO_X8:
      begin
        ratio_on = 1'b1;
        shift_d  = 2'b11;
      end
      default:
      begin
        ratio_on = 1'b0;
        shift_d  = 2'b00;
      end
    endcase
  end

  // converter controls from the stored configuration
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      conv_ctrl_q <= '0;
    end
    else
    begin
      conv_ctrl_q.power_state <= config_one_q[C1_POWER_BIT];
      conv_ctrl_q.reference_source_select <= config_one_q[C1_REF_SRC_BIT];
      conv_ctrl_q.resolution_boost <= config_one_q[C1_BOOST_BIT] & ratio_on;
      conv_ctrl_q.averaging_shift <= shift_d;
      conv_ctrl_q.output_lane_select <= lane_q;
      conv_ctrl_q.second_pin_flag <= lane_q & config_one_q[C1_ALERT_EN_BIT];
    end
  end

  // reset command pulses; other codes leave both low
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      reset_cmd_q <= '0;
    end
    else
    begin
      reset_cmd_q.flush <= soft_hit | hard_hit;
      reset_cmd_q.config_reload <= hard_hit;
    end
  end

  // alert flags; a read clears the checksum bit only if it returned it
  assign crc_clr = (rd_take & (idx == IDX_ALERT) & readdata_q[AL_CRC_BIT])
                   | soft_hit | hard_hit;

  sticky_flag u_crc_flag
  (
    .clock  (clock),
    .resetn (resetn),
    .set    (crc_reject_pulse),
    .clr    (crc_clr),
    .q      (crc_flag)
  );

  sticky_flag u_load_flag
  (
    .clock  (clock),
    .resetn (resetn),
    .set    (load_fail_pulse),
    .clr    (hard_hit),
    .q      (load_flag)
  );

  // second pin shows any alert when it carries the flag
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      flag_pin_q <= 1'b0;
    end
    else
    begin
      flag_pin_q <= conv_ctrl_q.second_pin_flag & (crc_flag | load_flag);
    end
  end

  // interrupt status, write one to clear
  assign irq_set = {hard_hit, soft_hit, load_fail_pulse, crc_reject_pulse};
  assign irq_clr = (wr_take & byteenable[0] & (idx == IDX_IRQ_STATUS))
                   ? writedata[IRQ_W-1:0] : '0;

  for (genvar i = 0; i < IRQ_W; i++)
  begin : g_irq
    sticky_flag u_irq_bit
    (
      .clock  (clock),
      .resetn (resetn),
      .set    (irq_set[i]),
      .clr    (irq_clr[i]),
      .q      (irq_status[i])
    );
  end

  // interrupt mask
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_mask_q <= IRQ_MASK_RST;
    end
    else if (wr_take & byteenable[0] & (idx == IDX_IRQ_MASK))
    begin
      irq_mask_q <= writedata[IRQ_W-1:0];
    end
  end

  // level interrupt
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(irq_status & irq_mask_q);
    end
  end

  // outputs
  assign waitrequest = waitrequest_q;
  assign readdata    = {16'h0000, readdata_q};
  assign conv_ctrl   = conv_ctrl_q;
  assign reset_cmd   = reset_cmd_q;
  assign flag_pin    = flag_pin_q;
  assign irq         = irq_q;

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  AST_BOOST_IGNORED: assert property (
    !ratio_on |=> !conv_ctrl_q.resolution_boost)
    else $error("resolution boost active without averaging");

  AST_BOOST_WIDEN: assert property (
    (ratio_on && config_one_q[C1_BOOST_BIT]) |=> conv_ctrl_q.resolution_boost)
    else $error("resolution boost missing");

  AST_REF_SOURCE: assert property (
    ##1 conv_ctrl_q.reference_source_select == $past(config_one_q[C1_REF_SRC_BIT]))
    else $error("reference select mismatch");

  AST_POWER: assert property (
    ##1 conv_ctrl_q.power_state == $past(config_one_q[C1_POWER_BIT]))
    else $error("power state mismatch");

  AST_ADDR_FIELD: assert property (
    (wr_take && idx == IDX_CONFIG_ONE && !field_ok) |=> $stable(config_one_q))
    else $error("write with wrong address field took effect");

  AST_LANE: assert property (
    (wr_take && lanes_ok && field_ok && idx == IDX_CONFIG_TWO && !hard_hit)
      |=> ##1 conv_ctrl_q.output_lane_select == $past(writedata[C2_LANE_BIT], 2))
    else $error("lane select not applied");

  AST_SOFT: assert property (
    soft_hit |=> reset_cmd_q.flush && !reset_cmd_q.config_reload
               && $stable(config_one_q) && (!crc_flag || $past(crc_reject_pulse)))
    else $error("soft reset misbehaved");

  AST_HARD: assert property (
    hard_hit |=> config_one_q == CONFIG_ONE_RST && !lane_q && !c2_seen_q)
    else $error("hard reset left registers set");

  AST_IGNORE: assert property (
    (wr_take && idx == IDX_CONFIG_TWO && !soft_hit && !hard_hit)
      |=> !reset_cmd_q.flush && !reset_cmd_q.config_reload)
    else $error("ignored code caused a reset");

  AST_CRC_SET: assert property (
    crc_reject_pulse |=> crc_flag ##1 (crc_flag || $past(crc_clr)))
    else $error("checksum flag not held");

  AST_LOAD_KEEP: assert property (
    (load_flag && rd_take && idx == IDX_ALERT && !hard_hit) |=> load_flag)
    else $error("load flag cleared by read");

  AST_LOAD_HARD: assert property (
    (hard_hit && !load_fail_pulse) |=> !load_flag && reset_cmd_q.config_reload)
    else $error("hard reset did not clear load flag or reload");

  AST_C2_READ: assert property (
    (read && waitrequest_q && idx == IDX_CONFIG_TWO)
      |=> readdata_q[15:8] == {(c2_seen_q ? IDX_CONFIG_TWO : 4'h0), 3'b000, lane_q})
    else $error("config two readback wrong");

  AST_ALERT_RO: assert property (
    (wr_take && idx == IDX_ALERT && !crc_reject_pulse && !load_fail_pulse)
      |=> $stable(load_flag) && !$rose(crc_flag))
    else $error("alert register changed by a write");

  AST_FLAG_PIN: assert property (
    !conv_ctrl_q.second_pin_flag |=> !flag_pin_q)
    else $error("flag pin driven while second lane carries data");

  AST_RATIO: assert property (
    (config_one_q[C1_RATIO_LO +: 3] > RATIO_X8) |=> conv_ctrl_q.averaging_shift == 2'b00)
    else $error("disabled ratio code enabled averaging");

  AST_READ_CLEAR: assert property (
    (rd_take && idx == IDX_ALERT && !readdata_q[AL_CRC_BIT] && crc_flag) |=> crc_flag)
    else $error("unreturned checksum flag lost");

  AST_WAIT_ONE: assert property (
    ((read || write) && waitrequest_q) |=> !waitrequest_q ##1 waitrequest_q)
    else $error("waitrequest not one cycle");

  COV_SOFT: cover property (soft_hit);
  COV_HARD_CLEARS: cover property (load_flag ##1 hard_hit);
  COV_ALERT_READ: cover property (crc_flag ##1 rd_take && idx == IDX_ALERT);
  COV_IRQ: cover property ($rose(irq_q));

endmodule
`default_nettype wire

// [rtl/adc_cfg_pkg.sv]
`default_nettype none
package adc_cfg_pkg;

  // bus and register widths
  localparam int unsigned BUS_W  = 32;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned IRQ_W  = 4;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CONFIG_ONE  = 4'h1;
  localparam logic [3:0] IDX_CONFIG_TWO  = 4'h2;
  localparam logic [3:0] IDX_ALERT       = 4'h3;
  localparam logic [3:0] IDX_IRQ_STATUS  = 4'h8;
  localparam logic [3:0] IDX_IRQ_MASK    = 4'h9;

  // address field carried in every configuration register word
  localparam int unsigned ADDR_FIELD_LO  = 12;

  // first configuration register fields
  localparam int unsigned C1_POWER_BIT   = 0;
  localparam int unsigned C1_REF_SRC_BIT = 1;
  localparam int unsigned C1_BOOST_BIT   = 2;
  localparam int unsigned C1_ALERT_EN_BIT = 3;
  localparam int unsigned C1_RATIO_LO    = 6;
  localparam logic [15:0] C1_WRITE_MASK  = 16'h03FF;

  // second configuration register fields
  localparam int unsigned C2_LANE_BIT    = 8;
  localparam int unsigned C2_CMD_LO      = 0;

  // alert register fields
  localparam int unsigned AL_LOAD_BIT    = 8;
  localparam int unsigned AL_CRC_BIT     = 9;

  // reset values
  localparam logic [15:0] CONFIG_ONE_RST = 16'h0000;
  localparam logic [15:0] CONFIG_TWO_RST = 16'h0000;
  localparam logic [15:0] ALERT_RST      = 16'h0000;
  localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;

  // reset command codes
  localparam logic [7:0] CMD_SOFT_RESET  = 8'h3C;
  localparam logic [7:0] CMD_HARD_RESET  = 8'hFF;

  // averaging ratio codes
  localparam logic [2:0] RATIO_X2        = 3'h1;
  localparam logic [2:0] RATIO_X4        = 3'h2;
  localparam logic [2:0] RATIO_X8        = 3'h3;

  // interrupt status bit positions
  localparam int unsigned IRQ_CRC_BIT    = 0;
  localparam int unsigned IRQ_LOAD_BIT   = 1;
  localparam int unsigned IRQ_SOFT_BIT   = 2;
  localparam int unsigned IRQ_HARD_BIT   = 3;

  // converter control bundle
  typedef struct packed {
    logic       power_state;
    logic       reference_source_select;
    logic       resolution_boost;
    logic [1:0] averaging_shift;
    logic       output_lane_select;
    logic       second_pin_flag;
  } conv_ctrl_t;

  // reset command pulses
  typedef struct packed {
    logic flush;
    logic config_reload;
  } reset_cmd_t;

endpackage
`default_nettype wire

// [rtl/sticky_flag.sv]
`default_nettype none
module sticky_flag
(
  // clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // event and clear
  input  wire logic set,
  input  wire logic clr,
  // flag
  output var  logic q
);

  // a set in the clear cycle wins
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= 1'b0;
    end
    else
    begin
      q <= set | (q & ~clr);
    end
  end

endmodule
`default_nettype wire

// [test/host_bus_master.sv]
`default_nettype none
module host_bus_master
(
  // clock
  input  wire logic        clock,
  // avalon-mm master side
  output var  logic [5:0]  address,
  output var  logic        read,
  output var  logic        write,
  output var  logic [31:0] writedata,
  output var  logic [3:0]  byteenable,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  // wait limit ran out
  output var  logic        bus_hang
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero
  initial
  begin
    address    = 6'h00;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h0000_0000;
    byteenable = 4'h0;
    bus_hang   = 1'b0;
  end

  // one transfer: raise after an edge, hold until waitrequest is sampled low
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge clock);
    address    <= a;
    read       <= rd;
    write      <= !rd;
    writedata  <= d; // caller puts the target index in [15:12]
    byteenable <= be;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    q = readdata; // read data taken at the accepting edge only
    if (n >= 64)
      bus_hang <= 1'b1;
    read  <= 1'b0;
    write <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/adc_config_alert_regs_tb_top.sv]
`default_nettype none
module adc_config_alert_regs_tb_top;
  import adc_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic                clock = 1'b0;
  logic                resetn = 1'b0;
  logic [5:0]          address;
  logic                read;
  logic                write;
  logic [31:0]         writedata;
  logic [3:0]          byteenable;
  logic [31:0]         readdata;
  logic                waitrequest;
  logic                crc_reject_pulse = 1'b0;
  logic                load_fail_pulse = 1'b0;
  conv_ctrl_t          conv_ctrl;
  reset_cmd_t          reset_cmd;
  logic                flag_pin;
  logic                irq;
  logic                bus_hang;
  logic [31:0]         q;
  int                  miscompares = 0;
  int                  cmp_count = 0;
  int                  flush_n = 0;
  int                  reload_n = 0;
  int                  f0;
  int                  r0;
  logic [7:0]          codes [5] = '{8'h00, 8'h3B, 8'h3D, 8'hFE, 8'hC3};

  // 125 MHz clock
  always #4 clock = ~clock;

  adc_config_alert_regs adc_config_alert_regs_inst (
    .clock(clock), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .crc_reject_pulse(crc_reject_pulse),
    .load_fail_pulse(load_fail_pulse), .conv_ctrl(conv_ctrl), .reset_cmd(reset_cmd),
    .flag_pin(flag_pin), .irq(irq));

  host_bus_master host_bus_master_inst (
    .clock(clock), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .bus_hang(bus_hang));

  // count cycles in which each reset command pulse is high
  always @(posedge clock)
  begin
    if (reset_cmd.flush === 1'b1)
      flush_n++;
    if (reset_cmd.config_reload === 1'b1)
      reload_n++;
    if (bus_hang === 1'b1)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [5:0] ba(input logic [3:0] i);
    return {i, 2'b00};
  endfunction

  // expected control bundle from the register fields
  function automatic logic [6:0] ectl(input logic [2:0] r, input logic rb, input logic rf,
                                      input logic pw, input logic ln, input logic sp);
    logic on;
    on = (r == RATIO_X2) || (r == RATIO_X4) || (r == RATIO_X8);
    return {pw, rf, rb & on, on ? r[1:0] : 2'b00, ln, sp};
  endfunction

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    host_bus_master_inst.xfer(1'b0, a, {16'h0000, d}, 4'hF, q);
  endtask

  task automatic rd(input logic [5:0] a);
    host_bus_master_inst.xfer(1'b1, a, 32'h0000_0000, 4'hF, q);
  endtask

  // controls lag the write by one edge; three edges leave margin
  task automatic settle();
    repeat (3) @(posedge clock);
  endtask

  task automatic pulse_crc();
    @(posedge clock) crc_reject_pulse <= 1'b1;
    @(posedge clock) crc_reject_pulse <= 1'b0;
    settle();
  endtask

  task automatic pulse_load();
    @(posedge clock) load_fail_pulse <= 1'b1;
    @(posedge clock) load_fail_pulse <= 1'b0;
    settle();
  endtask

  // main sequence
  initial
  begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    rd(ba(IDX_CONFIG_TWO)); check(q, 32'h0);
    rd(ba(IDX_ALERT)); check(q, 32'h0);
    check(conv_ctrl, 7'h00);
    // ratio codes with boost, reference and shutdown bits set
    wr(ba(IDX_CONFIG_ONE), {IDX_CONFIG_ONE, 12'h007});
    settle(); check(conv_ctrl, ectl(3'h0, 1, 1, 1, 0, 0));
    for (int r = 1; r < 8; r++)
    begin
      wr(ba(IDX_CONFIG_ONE), {IDX_CONFIG_ONE, 3'h0, r[2:0], 6'h07});
      settle(); check(conv_ctrl, ectl(r[2:0], 1, 1, 1, 0, 0));
    end
    wr(ba(IDX_CONFIG_ONE), {IDX_CONFIG_ONE, 12'h0C0});
    settle(); check(conv_ctrl, ectl(3'h3, 0, 0, 0, 0, 0));
    // wrong address field and missing byte lane are both refused
    wr(ba(IDX_CONFIG_ONE), 16'h2001);
    host_bus_master_inst.xfer(1'b0, ba(IDX_CONFIG_ONE), 32'h1001, 4'h1, q);
    settle(); check(conv_ctrl, ectl(3'h3, 0, 0, 0, 0, 0));
    // one-wire output and second pin flag
    wr(ba(IDX_CONFIG_TWO), {IDX_CONFIG_TWO, 12'h100});
    rd(ba(IDX_CONFIG_TWO)); check(q, 32'h2100);
    wr(ba(IDX_CONFIG_ONE), {IDX_CONFIG_ONE, 12'h008});
    settle(); check(conv_ctrl, ectl(3'h0, 0, 0, 0, 1, 1));
    pulse_crc(); check(flag_pin, 1'b1);
    wr(ba(IDX_CONFIG_TWO), {IDX_CONFIG_TWO, 12'h000});
    settle(); check(conv_ctrl, ectl(3'h0, 0, 0, 0, 0, 0));
    check(flag_pin, 1'b0);
    wr(ba(IDX_CONFIG_TWO), {IDX_CONFIG_TWO, 12'h100});
    // sticky alert flags
    rd(ba(IDX_ALERT)); check(q, 32'h0200);
    rd(ba(IDX_ALERT)); check(q, 32'h0000);
    pulse_load();
    rd(ba(IDX_ALERT)); check(q, 32'h0100);
    rd(ba(IDX_ALERT)); check(q, 32'h0100);
    wr(ba(IDX_ALERT), 16'h3300);
    rd(ba(IDX_ALERT)); check(q, 32'h0100);
    // soft reset keeps registers and clears the checksum flag
    pulse_crc();
    f0 = flush_n;
    r0 = reload_n;
    wr(ba(IDX_CONFIG_TWO), {IDX_CONFIG_TWO, 4'h1, CMD_SOFT_RESET});
    settle(); check(flush_n - f0, 1);
    check(reload_n - r0, 0);
    rd(ba(IDX_ALERT)); check(q, 32'h0100);
    check(conv_ctrl, ectl(3'h0, 0, 0, 0, 1, 1));
    // other command codes do nothing
    foreach (codes[i])
    begin
      wr(ba(IDX_CONFIG_TWO), {IDX_CONFIG_TWO, 4'h1, codes[i]});
      settle();
    end
    check(flush_n - f0, 1);
    check(reload_n - r0, 0);
    rd(ba(IDX_CONFIG_TWO)); check(q, 32'h2100);
    rd(ba(IDX_ALERT)); check(q, 32'h0100);
    // hard reset restores defaults and reruns the load
    wr(ba(IDX_CONFIG_TWO), {IDX_CONFIG_TWO, 4'h0, CMD_HARD_RESET});
    settle(); check(flush_n - f0, 2);
    check(reload_n - r0, 1);
    check(conv_ctrl, 7'h00);
    rd(ba(IDX_CONFIG_TWO)); check(q, 32'h0);
    rd(ba(IDX_ALERT)); check(q, 32'h0);
    // interrupt: clear, unmask checksum only, mask out, raise, clear
    wr(ba(IDX_IRQ_STATUS), 16'h000F);
    wr(ba(IDX_IRQ_MASK), 16'h0001);
    rd(ba(IDX_IRQ_MASK)); check(q, 32'h1);
    settle(); check(irq, 1'b0);
    pulse_load(); check(irq, 1'b0);
    rd(ba(IDX_IRQ_STATUS)); check(q, 32'h2);
    pulse_crc(); check(irq, 1'b1);
    rd(ba(IDX_IRQ_STATUS)); check(q, 32'h3);
    wr(ba(IDX_IRQ_STATUS), 16'h0001);
    settle(); check(irq, 1'b0);
    rd(ba(IDX_IRQ_STATUS)); check(q, 32'h2);
    // unmapped place reads zero and ignores writes
    wr(6'h30, 16'hFFFF);
    rd(6'h30); check(q, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
